// file: exid_decode.sv
`timescale 1ns/1ps
// Function
// - Add 6-bit literal to selected file select pointer, one cycle, flags kept.
// - Selector 11 adds to frame pointer then returns; second cycle is idle.
// - Indirect call pushes program counter plus two onto return stack.
// - Then loads counter low from working register, high/upper from latches.
// - Indirect call is two cycles; working register, status, bank untouched.
// - Indexed-to-file move is two words: 7-bit offset, then 12-bit target.
// - Source is frame pointer plus offset, anywhere in data space.
// - Source in an indirect register reads as zero instead.
// - Push stores literal at frame pointer address in one cycle.
// - Subtract 6-bit literal from selected pointer, one cycle, flags kept.
// - Selector 11 subtracts from frame pointer then returns, two cycles.
// - Extended opcodes are recognised only with the enable bit set.
// - Push then decrements the frame pointer by one.
// - Indexed-to-indexed move; both addresses offset; indirect target is skipped.
module exid_decode
  import exid_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Configuration
  input  wire logic             extendedSetEnable,
  // Instruction stream
  input  wire logic             instrValid,
  input  wire logic [15:0]      instrWord,
  input  wire logic [PC_W-1:0]  pcCurrent,
  // Core state inputs
  input  wire logic [7:0]       workingRegister,
  input  wire logic [7:0]       counterLatchHigh,
  input  wire logic [7:0]       counterLatchUpper,
  input  wire logic [PC_W-1:0]  returnStackTop,
  // Data memory
  input  wire logic [7:0]       memRdata,
  output logic [PTR_W-1:0]      memAddr,
  output logic [7:0]            memWdata,
  output logic                  memWe,
  output logic                  memRe,
  // Return stack and program counter
  output logic                  stackPush,
  output logic                  stackPop,
  output logic [PC_W-1:0]       stackPushData,
  output logic                  pcLoad,
  output logic [PC_W-1:0]       pcLoadValue,
  // Status
  output logic                  extHandled,
  output logic                  busy,
  output logic [PTR_W-1:0]      filePtr0,
  output logic [PTR_W-1:0]      filePtr1,
  output logic [PTR_W-1:0]      stackFramePointer
);

  // ****************************************************************
  // State
  // ****************************************************************
  exid_state_t      state_q, state_d;
  logic [PTR_W-1:0] ptr_q [3];
  logic [7:0]       moveData_q;
  logic             srcZero_q;
  logic [7:0]       srcByte;

  exid_mem_if memBus ();

  // ****************************************************************
  // Field decode
  // ****************************************************************
  wire [7:0]       opHi      = instrWord[15:8];
  wire [1:0]       sel       = instrWord[SEL_POS+1:SEL_POS];
  wire [7:0]       lit6      = {2'h0, instrWord[LIT_W-1:0]};
  wire [7:0]       ofs7      = {1'b0, instrWord[OFS_W-1:0]};
  wire             isMovss   = instrWord[MOVS_SS_BIT];
  wire             inFetch   = (state_q == EXID_FETCH);
  wire             go        = inFetch & instrValid & extendedSetEnable;
  wire             isAdd     = go && (opHi == OP_ADD_HI);
  wire             isSub     = go && (opHi == OP_SUB_HI);
  wire             isPush    = go && (opHi == OP_PUSH_HI);
  wire             isMovs    = go && (opHi == OP_MOVS_HI);
  wire             isCallw   = go && (instrWord == OP_CALL_VIA_WORKING_REGISTER);
  wire             isAdjust  = isAdd | isSub;
  wire             isReturn  = isAdjust && (sel == SEL_FRAME);
  wire [1:0]       ptrIdx    = isReturn ? FRAME_IDX : sel;
  wire             second    = instrValid && (instrWord[15:12] == OP_SECOND_HI);
  wire [PTR_W-1:0] frame     = ptr_q[FRAME_IDX];
  wire             inMove2   = (state_q == EXID_MOVSF2) || (state_q == EXID_MOVSS2);

  // ****************************************************************
  // Pointer adders
  // ****************************************************************
  logic [PTR_W-1:0] adjResult;
  logic [PTR_W-1:0] ofsAddr;
  logic [PTR_W-1:0] pushNext;

  exid_ptr_alu uAdj (
    .ptrIn    (ptr_q[ptrIdx]),
    .lit      (lit6),
    .subtract (isSub),
    .ptrOut   (adjResult)
  );

  // Offset is the first word's in cycle one, the second word's in cycle two
  exid_ptr_alu uOfs (
    .ptrIn    (frame),
    .lit      (ofs7),
    .subtract (1'b0),
    .ptrOut   (ofsAddr)
  );

  exid_ptr_alu uPush (
    .ptrIn    (frame),
    .lit      (8'h01),
    .subtract (1'b1),
    .ptrOut   (pushNext)
  );

  // ****************************************************************
  // Memory request
  // ****************************************************************
  // Move destination: absolute 12 bits or frame-relative offset
  wire [PTR_W-1:0] dstAddr  = (state_q == EXID_MOVSF2) ? instrWord[PTR_W-1:0] : ofsAddr;
  wire             dstIndir = (state_q == EXID_MOVSS2) && memBus.srcIndirect;
  assign memBus.addr  = isPush ? frame : (inMove2 ? dstAddr : ofsAddr);
  assign memBus.wdata = isPush ? instrWord[7:0] : moveData_q;
  assign memBus.we    = isPush | (inMove2 & second & ~dstIndir);
  assign memBus.re    = isMovs;
  assign srcByte      = memBus.srcIndirect ? ZERO_BYTE : memRdata;

  exid_mem_port uPort (
    .req      (memBus.port),
    .memAddr  (memAddr),
    .memWdata (memWdata),
    .memWe    (memWe),
    .memRe    (memRe)
  );

  // ****************************************************************
  // Return stack and program counter
  // ****************************************************************
  // Call pushes next address; working register and latches form target
  assign stackPush     = isCallw;
  assign stackPushData = PC_W'(pcCurrent + PC_STEP);
  assign stackPop      = isReturn;
  assign pcLoad        = isCallw | isReturn;
  assign pcLoadValue   = isCallw ? {counterLatchUpper[4:0], counterLatchHigh, workingRegister}
                                 : returnStackTop;
  assign extHandled    = isAdd | isSub | isPush | isMovs | isCallw | (inMove2 & second);
  assign busy          = ~inFetch;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Two-cycle forms hold the sequencer so the fetched word is discarded
  always_comb begin
    state_d = state_q;
    case (state_q)
      EXID_FETCH: begin
        if (isCallw || isReturn) begin
          state_d = EXID_NOP2;
        end else if (isMovs) begin
          state_d = isMovss ? EXID_MOVSS2 : EXID_MOVSF2;
        end
      end
      EXID_NOP2: begin
        state_d = EXID_FETCH;
      end
      EXID_MOVSF2, EXID_MOVSS2: begin
        if (second) begin
          state_d = EXID_FETCH;
        end
      end
      default: begin
        state_d = EXID_FETCH;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= EXID_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  // Pointers; status flags are never touched by these opcodes
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q[0] <= PTR_RESET;
      ptr_q[1] <= PTR_RESET;
      ptr_q[2] <= PTR_RESET;
    end else if (isAdjust) begin
      ptr_q[ptrIdx] <= adjResult;
    end else if (isPush) begin
      ptr_q[FRAME_IDX] <= pushNext;
    end
  end

  // Source byte captured in cycle one, written in cycle two
  always_ff @(posedge clk) begin
    if (rst) begin
      moveData_q <= ZERO_BYTE;
      srcZero_q  <= 1'b0;
    end else if (isMovs) begin
      moveData_q <= srcByte;
      srcZero_q  <= memBus.srcIndirect;
    end
  end

  assign filePtr0          = ptr_q[0];
  assign filePtr1          = ptr_q[1];
  assign stackFramePointer = ptr_q[FRAME_IDX];

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_add_ptr_update: assert property (@(posedge clk) disable iff (rst)
    isAdd && !isReturn |=> ptr_q[$past(sel)] == $past(ptr_q[sel] + {4'h0, lit6}))
    else $error("pointer add wrong");
  a_addret_twocyc: assert property (@(posedge clk) disable iff (rst)
    isReturn |-> pcLoad && pcLoadValue == returnStackTop ##1 busy && !pcLoad ##1 !busy)
    else $error("adjust-and-return sequence wrong");
  a_call_push_pc: assert property (@(posedge clk) disable iff (rst)
    isCallw |-> stackPush && stackPushData == PC_W'(pcCurrent + 21'h2))
    else $error("call push address wrong");
  a_call_target: assert property (@(posedge clk) disable iff (rst)
    isCallw |-> pcLoadValue[7:0] == workingRegister && pcLoadValue[15:8] == counterLatchHigh)
    else $error("call target wrong");
  a_call_nop: assert property (@(posedge clk) disable iff (rst)
    isCallw |=> busy && !memWe && !stackPush && !pcLoad)
    else $error("call second cycle not idle");
  a_move_indexed_to_file_dest: assert property (@(posedge clk) disable iff (rst)
    state_q == EXID_MOVSF2 && second |-> memWe && memAddr == instrWord[11:0]
    && memWdata == moveData_q)
    else $error("move destination wrong");
  a_move_src_addr: assert property (@(posedge clk) disable iff (rst)
    isMovs |-> memAddr == PTR_W'(frame + {5'h0, instrWord[6:0]}))
    else $error("move source address wrong");
  a_indir_zero: assert property (@(posedge clk) disable iff (rst)
    isMovs && memBus.srcIndirect |=> moveData_q == 8'h00)
    else $error("indirect source not zero");
  a_push_store: assert property (@(posedge clk) disable iff (rst)
    isPush |-> memWe && memAddr == frame && memWdata == instrWord[7:0]
    ##1 stackFramePointer == PTR_W'($past(frame) - 12'h001))
    else $error("push wrong");
  a_sub_ptr_update: assert property (@(posedge clk) disable iff (rst)
    isSub && !isReturn |=> ptr_q[$past(sel)] == $past(ptr_q[sel] - {4'h0, lit6}))
    else $error("pointer subtract wrong");
  a_subret_frame: assert property (@(posedge clk) disable iff (rst)
    isSub && isReturn |=> stackFramePointer == $past(frame - {4'h0, lit6}))
    else $error("subtract-and-return frame wrong");
  a_disabled_idle: assert property (@(posedge clk) disable iff (rst)
    !extendedSetEnable && inFetch |-> !extHandled && !memWe && !pcLoad)
    else $error("extended opcode active while disabled");
  a_move_indexed_to_indexed_indir_nop: assert property (@(posedge clk) disable iff (rst)
    state_q == EXID_MOVSS2 && memBus.srcIndirect |-> !memWe)
    else $error("indirect destination written");

  // ****************************************************************
  // Sequencer, strobe, pointer, target and data checks
  // ****************************************************************
  // Cycle counts matter to the core's fetch: a stray busy cycle loses a word
  a_addret_frame: assert property (@(posedge clk) disable iff (rst)
    isAdd && isReturn |=> stackFramePointer == $past(frame + {4'h0, lit6}))
    else $error("add-and-return frame wrong");
  a_call_upper: assert property (@(posedge clk) disable iff (rst)
    isCallw |-> pcLoadValue[20:16] == counterLatchUpper[4:0])
    else $error("call upper target wrong");
  a_call_twocyc: assert property (@(posedge clk) disable iff (rst)
    isCallw |=> busy ##1 !busy)
    else $error("call not two cycles");
  a_busy_no_flow: assert property (@(posedge clk) disable iff (rst)
    busy |-> !stackPush && !stackPop && !pcLoad)
    else $error("flow change in idle cycle");
  a_adjust_onecyc: assert property (@(posedge clk) disable iff (rst)
    isAdjust && !isReturn |=> !busy)
    else $error("pointer adjust not one cycle");
  a_adjust_no_mem: assert property (@(posedge clk) disable iff (rst)
    isAdjust |-> !memWe && !memRe)
    else $error("pointer adjust touched memory");
  a_push_onecyc: assert property (@(posedge clk) disable iff (rst)
    isPush |=> !busy)
    else $error("push not one cycle");
  a_move_wait: assert property (@(posedge clk) disable iff (rst)
    isMovs |=> busy)
    else $error("move did not wait for second word");
  a_move_read: assert property (@(posedge clk) disable iff (rst)
    isMovs && !memBus.srcIndirect |-> memRe)
    else $error("move source not read");
  a_indir_no_read: assert property (@(posedge clk) disable iff (rst)
    memBus.srcIndirect |-> !memRe)
    else $error("indirect register read");
  // Captured flag keeps the zero substitution visible at the write
  a_move_indexed_to_file_zero_src: assert property (@(posedge clk) disable iff (rst)
    state_q == EXID_MOVSF2 && srcZero_q |-> memWdata == ZERO_BYTE)
    else $error("indirect source byte not zero");
  a_move_indexed_to_indexed_dst_addr: assert property (@(posedge clk) disable iff (rst)
    state_q == EXID_MOVSS2 |-> memAddr == PTR_W'(frame + {5'h0, instrWord[6:0]}))
    else $error("indexed destination address wrong");
  a_disabled_ptrs: assert property (@(posedge clk) disable iff (rst)
    !extendedSetEnable && inFetch |=> filePtr0 == $past(filePtr0)
    && filePtr1 == $past(filePtr1)
    && stackFramePointer == $past(stackFramePointer))
    else $error("pointer changed while disabled");

endmodule

// file: exid_pkg.sv
package exid_pkg;

  // ****************************************************************
  // Opcode patterns
  // ****************************************************************
  localparam logic [7:0]  OP_ADD_HI    = 8'he8;
  localparam logic [7:0]  OP_SUB_HI    = 8'he9;
  localparam logic [7:0]  OP_PUSH_HI   = 8'hea;
  localparam logic [7:0]  OP_MOVS_HI   = 8'heb;
  localparam logic [3:0]  OP_SECOND_HI = 4'hf;
  localparam logic [15:0] OP_CALL_VIA_WORKING_REGISTER     = 16'h0014;
  localparam logic [1:0]  SEL_FRAME    = 2'h3;
  localparam int          SEL_POS      = 6;
  localparam int          LIT_W        = 6;
  localparam int          OFS_W        = 7;
  localparam int          MOVS_SS_BIT  = 7;

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int          PTR_W        = 12;
  localparam int          PC_W         = 21;
  localparam logic [11:0] PTR_RESET    = 12'h000;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [1:0]  FRAME_IDX    = 2'h2;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    EXID_FETCH,
    EXID_NOP2,
    EXID_MOVSF2,
    EXID_MOVSS2
  } exid_state_t;

endpackage

// file: exid_mem_if.sv
`timescale 1ns/1ps
// Data memory request bundle between sequencer and port module
interface exid_mem_if;
  import exid_pkg::*;
  logic [PTR_W-1:0] addr;
  logic [7:0]       wdata;
  logic             we;
  logic             re;
  logic             srcIndirect;
  modport master (output addr, wdata, we, re, input srcIndirect);
  modport port   (input addr, wdata, we, re, output srcIndirect);
endinterface

// file: exid_ptr_alu.sv
`timescale 1ns/1ps
// Pointer adder for literal adjust; wraps at pointer width
module exid_ptr_alu
  import exid_pkg::*;
(
  // Operands
  input  wire logic [PTR_W-1:0] ptrIn,
  input  wire logic [7:0]       lit,
  input  wire logic             subtract,
  // Result
  output logic [PTR_W-1:0]      ptrOut
);
  // ****************************************************************
  // Modular arithmetic
  // ****************************************************************
  // Carry and borrow are dropped; no flag consumes them
  wire [PTR_W-1:0] litExt = {{(PTR_W-8){1'b0}}, lit};
  assign ptrOut = subtract ? PTR_W'(ptrIn - litExt) : PTR_W'(ptrIn + litExt);
endmodule

// file: exid_mem_port.sv
`timescale 1ns/1ps
// Data memory port: drives memory pins and flags indirect registers
module exid_mem_port
  import exid_pkg::*;
#(
  parameter logic [PTR_W-1:0] INDF_BASE = 12'hfef,
  parameter logic [PTR_W-1:0] INDF_STEP = 12'h008,
  parameter int               INDF_NUM  = 3,
  parameter int               INDF_SPAN = 5
) (
  // Request side
  exid_mem_if.port  req,
  // Memory side
  output logic [PTR_W-1:0] memAddr,
  output logic [7:0]       memWdata,
  output logic             memWe,
  output logic             memRe
);
  // ****************************************************************
  // Indirect register window detect
  // ****************************************************************
  logic [INDF_NUM-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < INDF_NUM; g++) begin : gIndf
      wire [PTR_W-1:0] lo = PTR_W'(INDF_BASE - PTR_W'(g) * INDF_STEP);
      assign hit[g] = (req.addr >= lo) && (req.addr < PTR_W'(lo + PTR_W'(INDF_SPAN)));
    end
  endgenerate
  assign req.srcIndirect = |hit;
  assign memAddr  = req.addr;
  assign memWdata = req.wdata;
  assign memWe    = req.we;
  assign memRe    = req.re & ~req.srcIndirect;
endmodule

// file: exid_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Data memory partner: combinational read, write on the clock
// ****************************************************************
module exid_mem_model
  import exid_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Request from the block
  input  wire logic [PTR_W-1:0] memAddr,
  input  wire logic [7:0]       memWdata,
  input  wire logic             memWe,
  input  wire logic             memRe,
  // Answer
  output logic      [7:0]       memRdata
);
  logic [7:0] store [0:4095];
  logic [7:0] lastRead;

  // Idle read bus shows the inverse of the last byte, so stale data never matches
  assign memRdata = memRe ? store[memAddr] : ~lastRead;

  // Write port and read history
  always @(posedge clk) begin
    if (memWe) begin
      store[memAddr] <= memWdata;
    end
    if (memRe) begin
      lastRead <= store[memAddr];
    end
  end

  initial begin
    lastRead = 8'h00;
  end
endmodule

// file: extended_instruction_decode_tb.sv
`timescale 1ns/1ps
module extended_instruction_decode_tb;
  import exid_pkg::*;
  logic clk, rst, extendedSetEnable, instrValid;
  logic [15:0] instrWord;
  logic [20:0] pcCurrent, returnStackTop, stackPushData, pcLoadValue;
  logic [7:0]  workingRegister, counterLatchHigh, counterLatchUpper, memRdata, memWdata;
  logic [11:0] memAddr, filePtr0, filePtr1, stackFramePointer;
  logic        memWe, memRe, stackPush, stackPop, pcLoad, extHandled, busy;
  int          miscompares, checksDone, cycles;

  exid_decode dut_u (.clk(clk), .rst(rst), .extendedSetEnable(extendedSetEnable),
    .instrValid(instrValid), .instrWord(instrWord), .pcCurrent(pcCurrent),
    .workingRegister(workingRegister), .counterLatchHigh(counterLatchHigh),
    .counterLatchUpper(counterLatchUpper), .returnStackTop(returnStackTop),
    .memRdata(memRdata), .memAddr(memAddr), .memWdata(memWdata), .memWe(memWe),
    .memRe(memRe), .stackPush(stackPush), .stackPop(stackPop),
    .stackPushData(stackPushData), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .extHandled(extHandled), .busy(busy), .filePtr0(filePtr0), .filePtr1(filePtr1),
    .stackFramePointer(stackFramePointer));
  exid_mem_model mem_u (.clk(clk), .memAddr(memAddr), .memWdata(memWdata),
    .memWe(memWe), .memRe(memRe), .memRdata(memRdata));

  // ****************************************************************
  // Clock, timeout and common tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run needs under a hundred cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      testDone();
    end
  end

  task automatic testDone();
    if (miscompares == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Present one word after the edge; returns with combinational answers settled
  task automatic drive(input logic valid, input logic [15:0] word);
    @(posedge clk);
    #1;
    instrValid = valid;
    instrWord  = word;
    #3;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic ptrOps();
    drive(1'b1, {OP_ADD_HI, 2'h0, 6'h3f});
    check("add handled", {20'h0, extHandled}, 21'h1);
    drive(1'b1, {OP_SUB_HI, 2'h1, 6'h01});
    check("sub not busy", {20'h0, busy}, 21'h0);
    drive(1'b1, {OP_ADD_HI, 2'h2, 6'h10});
    drive(1'b0, 16'h0000);
    check("ptr0", {9'h0, filePtr0}, 21'h03f);
    check("ptr1 wrap", {9'h0, filePtr1}, 21'h0fff);
    check("frame", {9'h0, stackFramePointer}, 21'h010);
  endtask

  task automatic adjustReturn();
    for (int i = 0; i < 2; i++) begin
      drive(1'b1, {(i == 0) ? OP_SUB_HI : OP_ADD_HI, SEL_FRAME, 6'h05});
      check("ret load", {19'h0, pcLoad, stackPop}, 21'h3);
      check("ret pc", pcLoadValue, returnStackTop);
      drive(1'b0, 16'h0000);
      check("ret busy", {20'h0, busy}, 21'h1);
      check("ret frame", {9'h0, stackFramePointer}, (i == 0) ? 21'h00b : 21'h010);
    end
  endtask

  task automatic callWord();
    drive(1'b1, OP_CALL_VIA_WORKING_REGISTER);
    check("call push", {20'h0, stackPush}, 21'h1);
    check("call ret addr", stackPushData, pcCurrent + PC_STEP);
    check("call target", pcLoadValue, {5'h1f, 8'h10, 8'h06});
    // A push offered in the idle cycle must be dropped
    drive(1'b1, {OP_PUSH_HI, 8'h99});
    check("call busy", {19'h0, busy, memWe}, 21'h2);
  endtask

  task automatic pushPair();
    drive(1'b1, {OP_PUSH_HI, 8'ha5});
    check("push 1", {memWe, memAddr, memWdata}, {1'b1, 12'h010, 8'ha5});
    drive(1'b1, {OP_PUSH_HI, 8'h5a});
    check("push 2", {memWe, memAddr, memWdata}, {1'b1, 12'h00f, 8'h5a});
    drive(1'b0, 16'h0000);
    check("push frame", {9'h0, stackFramePointer}, 21'h00e);
    check("push mem", {13'h0, mem_u.store[12'h010]}, 21'h0a5);
  endtask

  // Destinations stay clear of counter and return stack bytes
  task automatic moveToFile(input logic [6:0] ofs, input logic [11:0] dst,
                            input logic [11:0] src, input logic [7:0] exp);
    mem_u.store[dst] = 8'hff;
    drive(1'b1, {OP_MOVS_HI, 1'b0, ofs});
    check("move_indexed_to_file src", {memAddr, memRe}, {src, exp != 8'h00});
    drive(1'b1, {OP_SECOND_HI, dst});
    check("move_indexed_to_file busy", {20'h0, busy}, 21'h1);
    check("move_indexed_to_file dst", {memWe, memAddr, memWdata}, {1'b1, dst, exp});
    drive(1'b0, 16'h0000);
    check("move_indexed_to_file mem", {13'h0, mem_u.store[dst]}, {13'h0, exp});
  endtask

  task automatic moveIndexed(input logic [6:0] dOfs, input logic expWe);
    drive(1'b1, {OP_MOVS_HI, 1'b1, 7'h07});
    drive(1'b1, {OP_SECOND_HI, 5'h0, dOfs});
    check("move_indexed_to_indexed dst", {memWe, memAddr}, {expWe, stackFramePointer + {5'h0, dOfs}});
    drive(1'b0, 16'h0000);
  endtask

  task automatic disabledSet();
    @(posedge clk);
    #1;
    extendedSetEnable = 1'b0;
    drive(1'b1, {OP_PUSH_HI, 8'h11});
    check("off ignored", {19'h0, extHandled, memWe}, 21'h0);
    drive(1'b0, 16'h0000);
    check("off frame", {9'h0, stackFramePointer}, 21'h0fee);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    extendedSetEnable = 1'b1;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    pcCurrent = 21'h000100;
    workingRegister = 8'h06;
    counterLatchHigh = 8'h10;
    counterLatchUpper = 8'hff;
    returnStackTop = 21'h012345;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    ptrOps();
    adjustReturn();
    callWord();
    pushPair();
    mem_u.store[12'h013] = 8'h33;
    moveToFile(7'h05, 12'h234, 12'h013, 8'h33);
    drive(1'b1, {OP_SUB_HI, 2'h2, 6'h20});
    drive(1'b0, 16'h0000);
    mem_u.store[12'hfef] = 8'h77;
    moveToFile(7'h01, 12'h235, 12'hfef, 8'h00);
    mem_u.store[12'hff5] = 8'h9c;
    moveIndexed(7'h08, 1'b1);
    check("move_indexed_to_indexed mem", {13'h0, mem_u.store[12'hff6]}, 21'h09c);
    moveIndexed(7'h01, 1'b0);
    disabledSet();
    testDone();
  end
endmodule
